// ==== hw/sdi_pkg.sv ====
// Purpose: Shared constants and types for the servo digital input decoder
// Assumes: One drive clock; terminals active high after the pin buffers
// Notes: Function codes, register offsets and status word weights live here
package sdi_pkg;

  // Terminal count and function code width
  localparam int SDI_NUM_DI = 6;
  localparam int SDI_FUNC_W = 5;

  // Input function codes
  localparam logic [4:0] SDI_FC_SERVO_ON = 5'h01;
  localparam logic [4:0] SDI_FC_FAULT_CLR = 5'h02;
  localparam logic [4:0] SDI_FC_GAIN_UP = 5'h03;
  localparam logic [4:0] SDI_FC_DEV_CLR = 5'h04;
  localparam logic [4:0] SDI_FC_CMD_REV = 5'h06;
  localparam logic [4:0] SDI_FC_PULSE_INH = 5'h07;
  localparam logic [4:0] SDI_FC_TRQ_LIM = 5'h09;
  localparam logic [4:0] SDI_FC_SPD_LIM = 5'h0A;
  localparam logic [4:0] SDI_FC_GEAR_NUM = 5'h0B;

  // Mode setting values
  localparam logic SDI_GAIN_MODE_INPUT = 1'h1;
  localparam logic SDI_DEV_CLR_EDGE = 1'h0;
  localparam logic SDI_DEV_CLR_LEVEL = 1'h1;

  // Register offsets and reset values
  localparam logic [15:0] SDI_OFS_BLOCK_SELECT = 16'h080C;
  localparam logic [15:0] SDI_OFS_BLOCK_STATUS = 16'h080D;
  localparam logic [15:0] SDI_OFS_BLOCK_FIRMWARE = 16'h080E;
  localparam logic [15:0] SDI_RST_BLOCK_SELECT = 16'h0000;
  localparam logic [15:0] SDI_RST_READ_DATA = 16'h0000;

  // Stored block range and status word composition
  localparam int SDI_NUM_BLOCKS = 25;
  localparam logic [15:0] SDI_BLOCK_MAX = 16'h0018;
  localparam logic [15:0] SDI_STATUS_MAX = 16'h5DBF;
  localparam logic [15:0] SDI_SERIES_WEIGHT = 16'h2710;
  localparam logic [15:0] SDI_INERTIA_WEIGHT = 16'h03E8;
  localparam logic [6:0] SDI_POWER_MIN = 7'h02;
  localparam logic [6:0] SDI_POWER_MAX = 7'h07;
  localparam logic [6:0] SDI_POWER_ALT = 7'h67;
  localparam logic [1:0] SDI_INERTIA_LOW = 2'h1;
  localparam logic [1:0] SDI_INERTIA_HIGH = 2'h3;

  // Control mode
  typedef enum logic [1:0] {SDI_MODE_POS, SDI_MODE_SPD, SDI_MODE_TRQ} sdi_mode_e;

  // Drive control outputs
  typedef struct packed {
    logic servo_enable;
    logic fault_clear;
    logic gain_boost;
    logic dev_clear;
    logic cmd_reverse;
    logic pulse_inhibit;
    logic torque_limit;
    logic speed_limit;
    logic gear_num2;
  } sdi_drive_s;

  // One stored parameter block
  typedef struct packed {
    logic [1:0] series;
    logic [1:0] inertia;
    logic [6:0] power;
    logic [15:0] firmware;
  } sdi_block_s;

  localparam sdi_drive_s SDI_RST_DRIVE = '0;
  localparam sdi_block_s SDI_RST_BLOCK = '0;

endpackage

// ==== hw/sdi_input_decoder.sv ====
// Purpose: Decode digital input terminals into drive controls; keypad block registers
// Assumes: Terminal pins are asynchronous; register port and settings are on mclk
// Notes: Pin to control output latency is three clock edges
`timescale 1ns/1ps

// Behaviour
// - Servo enable terminal level holds the drive enabled in every mode.
// - Code 02 rising edge pulses fault clear in every mode.
// - Code 03 level with gain mode 1 selects the boosted loop gain.
// - Code 04 rising edge with clear mode 0 zeroes deviation once, position mode.
// - Clear mode 1 holds deviation zero while the clear terminal is active, position mode.
// - Code 06 level reverses motor command in speed and torque modes.
// - Code 07 level blocks the pulse train command in position mode.
// - Codes 05, 08, 12 and 13 carry no behaviour at all.
// - Code 09 level applies torque limit in speed and position modes.
// - Code 10 level applies speed limit in torque mode.
// - Code 11 selects second gear numerator when active, first otherwise, position mode.
// - Block selector accepts 0 to 24 and picks the shown stored block.
// - Status register reports the selected block status within 0 to 23999.
// - Status of a loaded block encodes power code 002-007 or 103 and inertia 1 to 3.
// - Firmware register reports the selected block firmware version.
module sdi_input_decoder
  import sdi_pkg::*;
#(
  parameter int NUM_DI = SDI_NUM_DI
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [NUM_DI-1:0] di_pin,
  input wire logic [NUM_DI*SDI_FUNC_W-1:0] input_function_assignment,
  input wire sdi_mode_e control_mode,
  input wire logic gain_switch_mode_setting,
  input wire logic deviation_clear_mode_setting,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic blk_load,
  input wire logic [4:0] blk_load_index,
  input wire sdi_block_s blk_load_data,
  output sdi_drive_s drive_ctrl
);

  // Terminals whose assigned code matches, with optional edge qualifier
  function automatic logic func_hit(input logic [NUM_DI*SDI_FUNC_W-1:0] assign_v,
                                    input logic [NUM_DI-1:0] lvl, input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (assign_v[i*SDI_FUNC_W +: SDI_FUNC_W] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Composed status value of a stored block
  function automatic logic [15:0] status_word(input sdi_block_s b);
    logic [31:0] sum;
    sum = 32'(b.series) * 32'(SDI_SERIES_WEIGHT) + 32'(b.inertia) * 32'(SDI_INERTIA_WEIGHT) + 32'(b.power);
    return sum[15:0];
  endfunction

  // True when any terminal holds a code with a defined behaviour
  // Reserved and unused codes leave this low, so the checks can demand idle controls
  function automatic logic known_assigned(input logic [NUM_DI*SDI_FUNC_W-1:0] assign_v);
    logic known;
    logic [4:0] code;
    known = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      code = assign_v[i*SDI_FUNC_W +: SDI_FUNC_W];
      if (code == SDI_FC_SERVO_ON || code == SDI_FC_FAULT_CLR || code == SDI_FC_GAIN_UP
          || code == SDI_FC_DEV_CLR || code == SDI_FC_CMD_REV || code == SDI_FC_PULSE_INH
          || code == SDI_FC_TRQ_LIM || code == SDI_FC_SPD_LIM || code == SDI_FC_GEAR_NUM) begin
        known = 1'b1;
      end
    end
    return known;
  endfunction

  logic [NUM_DI-1:0] sync1_ff, sync2_ff, prev_ff;
  logic [NUM_DI-1:0] nxt_sync1, nxt_sync2, nxt_prev;
  logic [NUM_DI-1:0] rise;
  sdi_drive_s drive_ff, nxt_drive;
  logic [15:0] select_ff, nxt_select;
  sdi_block_s blocks_ff [SDI_NUM_BLOCKS];
  sdi_block_s nxt_blocks [SDI_NUM_BLOCKS];
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic power_ok, inertia_ok;
  logic pos_mode, spd_mode, trq_mode;
  sdi_block_s shown_blk;

  // Two-stage synchroniser and previous sample per terminal
  genvar g;
  generate
    for (g = 0; g < NUM_DI; g++) begin : g_sync
      always_comb begin
        nxt_sync1[g] = di_pin[g];
        nxt_sync2[g] = sync1_ff[g];
        nxt_prev[g] = sync2_ff[g];
        rise[g] = sync2_ff[g] & ~prev_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  assign pos_mode = (control_mode == SDI_MODE_POS);
  assign spd_mode = (control_mode == SDI_MODE_SPD);
  assign trq_mode = (control_mode == SDI_MODE_TRQ);

  // Function decode; reserved codes have no case and so do nothing
  always_comb begin
    nxt_drive = SDI_RST_DRIVE;
    nxt_drive.servo_enable = func_hit(input_function_assignment, sync2_ff, SDI_FC_SERVO_ON);
    nxt_drive.fault_clear = func_hit(input_function_assignment, rise, SDI_FC_FAULT_CLR);
    nxt_drive.gain_boost = func_hit(input_function_assignment, sync2_ff, SDI_FC_GAIN_UP)
                           && gain_switch_mode_setting == SDI_GAIN_MODE_INPUT;
    if (pos_mode && deviation_clear_mode_setting == SDI_DEV_CLR_EDGE) begin
      nxt_drive.dev_clear = func_hit(input_function_assignment, rise, SDI_FC_DEV_CLR);
    end else if (pos_mode) begin
      nxt_drive.dev_clear = func_hit(input_function_assignment, sync2_ff, SDI_FC_DEV_CLR);
    end
    nxt_drive.cmd_reverse = (spd_mode || trq_mode)
                            && func_hit(input_function_assignment, sync2_ff, SDI_FC_CMD_REV);
    nxt_drive.pulse_inhibit = pos_mode
                              && func_hit(input_function_assignment, sync2_ff, SDI_FC_PULSE_INH);
    nxt_drive.torque_limit = (pos_mode || spd_mode)
                             && func_hit(input_function_assignment, sync2_ff, SDI_FC_TRQ_LIM);
    nxt_drive.speed_limit = trq_mode
                            && func_hit(input_function_assignment, sync2_ff, SDI_FC_SPD_LIM);
    nxt_drive.gear_num2 = pos_mode
                          && func_hit(input_function_assignment, sync2_ff, SDI_FC_GEAR_NUM);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drive_ff <= SDI_RST_DRIVE;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign drive_ctrl = drive_ff;

  // Block store loads only entries with legal power and inertia codes
  always_comb begin
    power_ok = (blk_load_data.power >= SDI_POWER_MIN && blk_load_data.power <= SDI_POWER_MAX)
               || blk_load_data.power == SDI_POWER_ALT;
    inertia_ok = blk_load_data.inertia >= SDI_INERTIA_LOW
                 && blk_load_data.inertia <= SDI_INERTIA_HIGH;
    nxt_blocks = blocks_ff;
    if (blk_load && 16'(blk_load_index) <= SDI_BLOCK_MAX && power_ok && inertia_ok
        && status_word(blk_load_data) <= SDI_STATUS_MAX) begin
      nxt_blocks[blk_load_index] = blk_load_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < SDI_NUM_BLOCKS; i++) begin
        blocks_ff[i] <= SDI_RST_BLOCK;
      end
    end else begin
      blocks_ff <= nxt_blocks;
    end
  end

  // Selector write; out-of-range values are dropped
  always_comb begin
    nxt_select = select_ff;
    if (reg_wr && reg_addr == SDI_OFS_BLOCK_SELECT && reg_wdata <= SDI_BLOCK_MAX) begin
      nxt_select = reg_wdata;
    end
  end

  // Read port, one cycle latency, unmapped reads return zero
  always_comb begin
    nxt_rvalid = reg_rd;
    nxt_rdata = SDI_RST_READ_DATA;
    if (!reg_rd) begin
      nxt_rdata = SDI_RST_READ_DATA;
    end else if (reg_addr == SDI_OFS_BLOCK_SELECT) begin
      nxt_rdata = select_ff;
    end else if (reg_addr == SDI_OFS_BLOCK_STATUS) begin
      nxt_rdata = status_word(blocks_ff[select_ff[4:0]]);
    end else if (reg_addr == SDI_OFS_BLOCK_FIRMWARE) begin
      nxt_rdata = blocks_ff[select_ff[4:0]].firmware;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      select_ff <= SDI_RST_BLOCK_SELECT;
      rdata_ff <= SDI_RST_READ_DATA;
      rvalid_ff <= 1'b0;
    end else begin
      select_ff <= nxt_select;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // Block currently named by the selector, watched by the store checks
  assign shown_blk = blocks_ff[select_ff[4:0]];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_sync_two_stage: assert property (sync2_ff == $past(di_pin, 2) || $past(reset, 2) || $past(reset))
    else $error("terminal sample not two stages behind pin");
  a_enable_level: assert property ($past(func_hit(input_function_assignment, sync2_ff, SDI_FC_SERVO_ON))
                                   |-> drive_ctrl.servo_enable)
    else $error("servo enable not held while terminal active");
  a_fault_clr_once: assert property (drive_ctrl.fault_clear |=> !drive_ctrl.fault_clear)
    else $error("fault clear longer than one cycle");
  a_gain_mode_gate: assert property (drive_ctrl.gain_boost |-> $past(gain_switch_mode_setting))
    else $error("gain boost without input gain mode");
  a_dev_edge_pulse: assert property (($past(deviation_clear_mode_setting) == SDI_DEV_CLR_EDGE
                                      && drive_ctrl.dev_clear) |=> !drive_ctrl.dev_clear
                                     || deviation_clear_mode_setting != SDI_DEV_CLR_EDGE)
    else $error("edge mode deviation clear repeated");
  a_dev_level_hold: assert property (($past(pos_mode) && $past(deviation_clear_mode_setting)
                                      && $past(func_hit(input_function_assignment, sync2_ff, SDI_FC_DEV_CLR)))
                                     |-> drive_ctrl.dev_clear)
    else $error("level mode deviation clear dropped");
  a_reverse_mode: assert property (drive_ctrl.cmd_reverse |-> !$past(pos_mode))
    else $error("command reverse in position mode");
  a_inhibit_mode: assert property (drive_ctrl.pulse_inhibit |-> $past(pos_mode))
    else $error("pulse inhibit outside position mode");
  a_limits_mode: assert property (!(drive_ctrl.torque_limit && drive_ctrl.speed_limit))
    else $error("torque and speed limit together");
  a_speed_lim_trq: assert property (drive_ctrl.speed_limit |-> $past(trq_mode))
    else $error("speed limit outside torque mode");
  a_gear_mode: assert property (drive_ctrl.gear_num2 |-> $past(pos_mode))
    else $error("gear numerator two outside position mode");
  a_select_range: assert property (reg_wr && reg_addr == SDI_OFS_BLOCK_SELECT
                                   |=> select_ff <= SDI_BLOCK_MAX)
    else $error("block selector out of range");
  a_status_range: assert property (reg_rvalid && $past(reg_addr) == SDI_OFS_BLOCK_STATUS
                                   |-> reg_rdata <= SDI_STATUS_MAX)
    else $error("status value out of range");
  a_fw_readback: assert property (reg_rvalid && $past(reg_addr) == SDI_OFS_BLOCK_FIRMWARE
                                  |-> reg_rdata == $past(blocks_ff[select_ff[4:0]].firmware))
    else $error("firmware read does not follow selector");

  // Exact edge and level checks on the decoded controls
  // All but a_reserved_quiet and a_torque_mode catch a control that is missing, not only one that shows up in the wrong mode
  a_fault_clr_edge: assert property (drive_ctrl.fault_clear
                                     == $past(func_hit(input_function_assignment, rise, SDI_FC_FAULT_CLR)))
    else $error("fault clear not tied to terminal rising edge");
  a_gain_level: assert property ($past(func_hit(input_function_assignment, sync2_ff, SDI_FC_GAIN_UP))
                                 && $past(gain_switch_mode_setting) |-> drive_ctrl.gain_boost)
    else $error("gain boost missing while terminal active");
  a_inhibit_level: assert property ($past(pos_mode)
                                    && $past(func_hit(input_function_assignment, sync2_ff, SDI_FC_PULSE_INH))
                                    |-> drive_ctrl.pulse_inhibit)
    else $error("pulse inhibit missing while terminal active");
  a_reserved_quiet: assert property (!$past(known_assigned(input_function_assignment))
                                     |-> drive_ctrl == SDI_RST_DRIVE)
    else $error("control raised with no defined function assigned");
  a_torque_mode: assert property (drive_ctrl.torque_limit |-> !$past(trq_mode))
    else $error("torque limit in torque mode");
  a_gear_level: assert property ($past(pos_mode)
                                 && $past(func_hit(input_function_assignment, sync2_ff, SDI_FC_GEAR_NUM))
                                 |-> drive_ctrl.gear_num2)
    else $error("second gear numerator missing while terminal active");

  // Register port and block store checks
  a_select_keep: assert property (reg_wr && reg_addr == SDI_OFS_BLOCK_SELECT && reg_wdata > SDI_BLOCK_MAX
                                  |=> $stable(select_ff))
    else $error("out of range selector write changed the selector");
  a_read_answer: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after the strobe");
  a_stored_codes: assert property (shown_blk == SDI_RST_BLOCK
                                   || ((shown_blk.power >= SDI_POWER_MIN && shown_blk.power <= SDI_POWER_MAX)
                                       || shown_blk.power == SDI_POWER_ALT)
                                   && shown_blk.inertia >= SDI_INERTIA_LOW)
    else $error("stored block holds an illegal power or inertia code");

  c_enable_seen: cover property (drive_ctrl.servo_enable);
  c_reverse_seen: cover property (drive_ctrl.cmd_reverse);
  c_fault_clear: cover property (drive_ctrl.fault_clear);
  c_dev_level: cover property (drive_ctrl.dev_clear [*3]);
  c_status_read: cover property (reg_rvalid && reg_rdata != 16'h0000);

endmodule

// ==== verif/sdi_ctrl_model.sv ====
// Purpose: Behavioural external controller that drives the input terminals
// Assumes: Terminals change just after a rising mclk edge
// Notes: Terminals idle low; the caller decides how long a pattern stays
`timescale 1ns/1ps
module sdi_ctrl_model
  import sdi_pkg::*;
(
  input wire logic mclk,
  output logic [SDI_NUM_DI-1:0] di_pin
);
  // Idle level from time zero
  initial begin
    di_pin = '0;
  end
  // Apply a new terminal pattern just after the next edge
  task automatic set_pins(input logic [SDI_NUM_DI-1:0] val);
    @(posedge mclk);
    #1;
    di_pin = val;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the digital input decoder and block registers
// Assumes: Inputs change 1 ns after a rising edge; outputs sampled 2 ns after
// Notes: Drivers note expectations in queues; a monitor compares as results appear
`timescale 1ns/1ps
module testbench
  import sdi_pkg::*;
;
  localparam logic [4:0] CODES [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D};
  logic mclk;
  logic reset;
  logic [SDI_NUM_DI-1:0] di_pin;
  logic [SDI_NUM_DI*SDI_FUNC_W-1:0] fn_asg;
  sdi_mode_e ctl_mode;
  logic gain_mode;
  logic clr_mode;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic blk_load;
  logic [4:0] blk_idx;
  sdi_block_s blk_data;
  sdi_drive_s drive_ctrl;
  sdi_block_s blk_a;
  sdi_block_s blk_b;
  logic look;
  logic [15:0] exp_rd[$];
  sdi_drive_s exp_dc[$];
  int err_total;
  int checked;
  int seed;
  int ti;

  sdi_input_decoder dut_u (.mclk(mclk), .reset(reset), .di_pin(di_pin), .input_function_assignment(fn_asg),
    .control_mode(ctl_mode), .gain_switch_mode_setting(gain_mode), .deviation_clear_mode_setting(clr_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .blk_load(blk_load), .blk_load_index(blk_idx), .blk_load_data(blk_data),
    .drive_ctrl(drive_ctrl));
  sdi_ctrl_model partner_u (.mclk(mclk), .di_pin(di_pin));

  task automatic check(input string what, input logic [26:0] seen, input logic [26:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    tick();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    tick();
    reg_rd = 1'b1;
    reg_addr = a;
    exp_rd.push_back(e);
    tick();
    reg_rd = 1'b0;
  endtask
  task automatic load(input logic [4:0] i, input sdi_block_s b);
    tick();
    blk_load = 1'b1;
    blk_idx = i;
    blk_data = b;
    tick();
    blk_load = 1'b0;
  endtask
  // Status word composed of decimal digit groups
  function automatic logic [15:0] stat(input sdi_block_s b);
    return 16'(b.series * 10000 + b.inertia * 1000 + b.power);
  endfunction
  // Expected controls for one active terminal; pulse selects the first cycle
  function automatic sdi_drive_s want(input logic [4:0] c, input int m, input logic pulse);
    sdi_drive_s d;
    d = SDI_RST_DRIVE;
    d.servo_enable = c == SDI_FC_SERVO_ON;
    d.fault_clear = pulse && c == SDI_FC_FAULT_CLR;
    d.gain_boost = c == SDI_FC_GAIN_UP && gain_mode == SDI_GAIN_MODE_INPUT;
    d.dev_clear = c == SDI_FC_DEV_CLR && m == 0 && (pulse || clr_mode == SDI_DEV_CLR_LEVEL);
    d.cmd_reverse = c == SDI_FC_CMD_REV && m != 0;
    d.pulse_inhibit = c == SDI_FC_PULSE_INH && m == 0;
    d.torque_limit = c == SDI_FC_TRQ_LIM && m != 2;
    d.speed_limit = c == SDI_FC_SPD_LIM && m == 2;
    d.gear_num2 = c == SDI_FC_GEAR_NUM && m == 0;
    return d;
  endfunction

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
  // Compare each result with the oldest note
  always @(posedge mclk) begin
    #2;
    if (reg_rvalid === 1'b1) check("reg_rdata", 27'(reg_rdata), exp_rd.size() ? 27'(exp_rd.pop_front()) : '1);
    if (look === 1'b1) check("drive_ctrl", 27'(drive_ctrl), 27'(exp_dc.pop_front()));
  end

  // Main sequence
  initial begin
    seed = 43565;
    reset = 1'b1;
    fn_asg = '0;
    ctl_mode = SDI_MODE_POS;
    gain_mode = 1'b0;
    clr_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    blk_load = 1'b0;
    blk_idx = '0;
    blk_data = SDI_RST_BLOCK;
    look = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    #1;
    reset = 1'b0;
    // Reset values, selector limit, read-only and unmapped places
    rd(SDI_OFS_BLOCK_SELECT, SDI_RST_BLOCK_SELECT);
    rd(SDI_OFS_BLOCK_STATUS, 16'h0000);
    rd(SDI_OFS_BLOCK_FIRMWARE, 16'h0000);
    wr(SDI_OFS_BLOCK_SELECT, SDI_BLOCK_MAX);
    wr(SDI_OFS_BLOCK_SELECT, SDI_BLOCK_MAX + 16'h0001);
    wr(SDI_OFS_BLOCK_STATUS, 16'h1234);
    rd(SDI_OFS_BLOCK_SELECT, SDI_BLOCK_MAX);
    rd(SDI_OFS_BLOCK_STATUS, 16'h0000);
    rd(16'h0810, 16'h0000);
    $display("test registers done");
    // Stored blocks follow the selector; illegal loads leave them alone
    blk_a = '{2'h2, SDI_INERTIA_HIGH, SDI_POWER_ALT, 16'($random(seed))};
    blk_b = '{2'h1, 2'h2, SDI_POWER_MAX, ~blk_a.firmware};
    load(5'h18, blk_a);
    load(5'h18, '{2'h1, SDI_INERTIA_LOW, 7'h08, 16'h0000});
    load(5'h19, blk_b);
    rd(SDI_OFS_BLOCK_STATUS, stat(blk_a));
    rd(SDI_OFS_BLOCK_FIRMWARE, blk_a.firmware);
    load(5'h03, blk_b);
    wr(SDI_OFS_BLOCK_SELECT, 16'h0003);
    rd(SDI_OFS_BLOCK_STATUS, stat(blk_b));
    rd(SDI_OFS_BLOCK_FIRMWARE, blk_b.firmware);
    $display("test blocks done");
    // Codes 01 to 13 on a random terminal in every mode; pulse then level, then release
    // Second pass turns both gain and clear mode settings on, so each setting is reached
    for (int m = 0; m < 6; m++) begin
      for (int k = 0; k < 13; k++) begin
        ti = $unsigned($random(seed)) % SDI_NUM_DI;
        tick();
        ctl_mode = sdi_mode_e'(m % 3);
        gain_mode = 1'(m / 3);
        clr_mode = 1'(m / 3);
        fn_asg = '0;
        fn_asg[ti*SDI_FUNC_W+:SDI_FUNC_W] = CODES[k];
        partner_u.set_pins(SDI_NUM_DI'(1) << ti);
        repeat (3) tick();
        exp_dc.push_back(want(CODES[k], m % 3, 1'b1));
        look = 1'b1;
        tick();
        exp_dc.push_back(want(CODES[k], m % 3, 1'b0));
        tick();
        look = 1'b0;
        partner_u.set_pins('0);
        repeat (3) tick();
        exp_dc.push_back(SDI_RST_DRIVE);
        look = 1'b1;
        tick();
        look = 1'b0;
      end
    end
    $display("test terminals done");
    for (int w = 0; w < 10 && exp_rd.size() > 0; w++) tick();
    check("queues", 27'(exp_rd.size() + exp_dc.size()), 27'h0000000);
    print_verdict();
  end
endmodule
